//--- core/orc_pkg.sv
// Function
// - Trip output stays active after activation until a valid reset is accepted.
// - Trip reset is accepted from keypad, emergency restart, external reset and remote serial command.
// - A fail-safe output keeps its relay energized when idle and drops it on activation or power loss.
// - Every trip reset request is ignored while a lockout interval is running.
// - Lockout time keeps counting without control power, crediting at most one hour while power is off.
// - The trip output asserts when any of fourteen enabled trip conditions asserts.
// - Default drive: trip fail-safe, alarm and first auxiliary non-fail-safe, second auxiliary fail-safe.
// - The alarm output is driven only by enabled alarm-level conditions, never by trip conditions.
// - The alarm output is separately selectable as latched or unlatched and fail-safe or not.
// - The first auxiliary output takes any mix of trip and alarm conditions, independent of the others.
// - The first auxiliary output is separately selectable as latched or unlatched and fail-safe or not.
// - The second auxiliary output is always latched and fail-safe, with an alarm-style condition mask.
// - A held external reset resets latched outputs whenever motor conditions allow (trip also needs no lockout running), like the keypad.
// - An emergency restart pulse clears thermal memory and takes one off the starts-per-hour count.
package orc_pkg;
    localparam int TRIP_W = 14;
    localparam int ALRM_W = 12;
    // Register offsets
    localparam logic [7:0] REG_TRIP_MASK = 8'h00;
    localparam logic [7:0] REG_ALRM_MASK = 8'h04;
    localparam logic [7:0] REG_AUX1_TMASK = 8'h08;
    localparam logic [7:0] REG_AUX1_AMASK = 8'h0C;
    localparam logic [7:0] REG_AUX2_MASK = 8'h10;
    localparam logic [7:0] REG_CONFIG = 8'h14;
    localparam logic [7:0] REG_COMMAND = 8'h18;
    localparam logic [7:0] REG_LOCKOUT = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_IRQ_STAT = 8'h24;
    localparam logic [7:0] REG_IRQ_CLR = 8'h28;
    localparam logic [7:0] REG_IRQ_EN = 8'h2C;
    // Config fields
    localparam int CFG_TRIP_FS = 0;
    localparam int CFG_ALRM_FS = 1;
    localparam int CFG_AUX1_FS = 2;
    localparam int CFG_ALRM_LATCH = 3;
    localparam int CFG_AUX1_LATCH = 4;
    // Only trip is fail-safe out of reset; aux2 is fail-safe by hardware
    localparam logic [4:0] CFG_RESET = 5'h01;
    // Command fields
    localparam int CMD_REMOTE_RESET = 0;
    // Reset values of masks
    localparam logic [13:0] TRIP_MASK_RESET = 14'h3F_FF;
    localparam logic [11:0] ALRM_MASK_RESET = 12'hF_FF;
    // Timing: seconds from 200 MHz clock
    localparam longint CLK_HZ = 200_000_000;
    localparam int SEC_PER_HOUR = 3600;
    localparam int LOCK_W = 24;
    localparam int IRQ_W = 4;
endpackage

//--- core/orc_out_chan.sv
`timescale 1ns/1ps
`default_nettype none
// One output relay channel: latch, reset and drive polarity
module orc_out_chan (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cond,
    input wire logic latch_en,
    input wire logic fail_safe,
    input wire logic reset_ok,
    output logic active,
    output logic coil
);
    // Latched output holds until a reset, unlatched follows cond
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            active <= 1'b0;
        end else if (cond) begin
            active <= 1'b1; // Set wins over a reset in the same cycle
        end else if (!latch_en || reset_ok) begin
            active <= 1'b0;
        end
    end

    // Coil drive; a powered-down coil is the fail-safe trip state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            coil <= 1'b0;
        end else if (fail_safe) begin
            coil <= !(cond || active);
        end else begin
            coil <= cond || active;
        end
    end
endmodule // orc_out_chan
`default_nettype wire

//--- core/orc_relay_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module orc_relay_ctrl #(
    parameter longint TICKS_PER_SEC = orc_pkg::CLK_HZ
) (
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Conditions from protection logic (same clock)
    input wire logic [orc_pkg::TRIP_W-1:0] trip_cond,
    input wire logic [orc_pkg::ALRM_W-1:0] alarm_cond,
    input wire logic motor_ok,
    input wire logic power_ok,
    input wire logic [11:0] off_seconds,
    input wire logic off_valid,
    // Pins
    input wire logic keypad_reset_pin,
    input wire logic ext_reset_pin,
    input wire logic emerg_restart_pin,
    // Outputs
    output logic trip_coil,
    output logic alarm_coil,
    output logic aux1_coil,
    output logic aux2_coil,
    output logic thermal_clear,
    output logic starts_dec,
    output logic irq
);
    logic [orc_pkg::TRIP_W-1:0] trip_mask;
    logic [orc_pkg::ALRM_W-1:0] alrm_mask;
    logic [orc_pkg::TRIP_W-1:0] aux1_tmask;
    logic [orc_pkg::ALRM_W-1:0] aux1_amask;
    logic [orc_pkg::ALRM_W-1:0] aux2_mask;
    logic [4:0] config_r;
    logic [orc_pkg::LOCK_W-1:0] lock_sec;
    logic [31:0] sec_cnt;
    logic sec_tick;
    logic [2:0] key_s;
    logic [2:0] ext_s;
    logic [2:0] emg_s;
    logic remote_reset;
    logic reset_req;
    logic reset_ok;
    logic emg_pulse;
    logic trip_c;
    logic alrm_c;
    logic aux1_c;
    logic aux2_c;
    logic trip_act;
    logic alrm_act;
    logic aux1_act;
    logic aux2_act;
    logic [orc_pkg::IRQ_W-1:0] irq_stat;
    logic [orc_pkg::IRQ_W-1:0] irq_en;
    logic [orc_pkg::IRQ_W-1:0] irq_evt;
    logic [orc_pkg::IRQ_W-1:0] irq_clr;
    logic [orc_pkg::IRQ_W-1:0] act_prev;
    logic lock_load;
    logic lock_active;
    logic [11:0] off_credit;

    // Pin synchronisers; bit 2 is the edge history
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            key_s <= 3'h0;
            ext_s <= 3'h0;
            emg_s <= 3'h0;
        end else begin
            key_s <= {key_s[1:0], keypad_reset_pin};
            ext_s <= {ext_s[1:0], ext_reset_pin};
            emg_s <= {emg_s[1:0], emerg_restart_pin};
        end
    end

    assign emg_pulse = emg_s[1] && !emg_s[2];
    assign remote_reset = reg_wr && (reg_addr == orc_pkg::REG_COMMAND)
        && reg_wdata[orc_pkg::CMD_REMOTE_RESET];
    // Keypad and held external reset need motor conditions to allow
    assign reset_req = ((key_s[1] && !key_s[2]) || ext_s[1]) && motor_ok
        || emg_pulse || remote_reset;
    assign lock_active = (lock_sec != '0);
    assign reset_ok = reset_req && !lock_active;

    // Condition combining per output
    assign trip_c = |(trip_cond & trip_mask);
    assign alrm_c = |(alarm_cond & alrm_mask);
    assign aux1_c = |(trip_cond & aux1_tmask)
        || |(alarm_cond & aux1_amask);
    assign aux2_c = |(alarm_cond & aux2_mask);

    // Trip is always latched; aux2 latched and fail-safe
    orc_out_chan u_trip (
        .clk(clk),
        .sys_rst(sys_rst),
        .cond(trip_c),
        .latch_en(1'b1),
        .fail_safe(config_r[orc_pkg::CFG_TRIP_FS]),
        .reset_ok(reset_ok),
        .active(trip_act),
        .coil(trip_coil)
    );
    orc_out_chan u_alrm (
        .clk(clk),
        .sys_rst(sys_rst),
        .cond(alrm_c),
        .latch_en(config_r[orc_pkg::CFG_ALRM_LATCH]),
        .fail_safe(config_r[orc_pkg::CFG_ALRM_FS]),
        .reset_ok(reset_req),
        .active(alrm_act),
        .coil(alarm_coil)
    );
    orc_out_chan u_aux1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .cond(aux1_c),
        .latch_en(config_r[orc_pkg::CFG_AUX1_LATCH]),
        .fail_safe(config_r[orc_pkg::CFG_AUX1_FS]),
        .reset_ok(reset_req),
        .active(aux1_act),
        .coil(aux1_coil)
    );
    orc_out_chan u_aux2 (
        .clk(clk),
        .sys_rst(sys_rst),
        .cond(aux2_c),
        .latch_en(1'b1),
        .fail_safe(1'b1),
        .reset_ok(reset_req),
        .active(aux2_act),
        .coil(aux2_coil)
    );

    // Configuration registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            trip_mask <= orc_pkg::TRIP_MASK_RESET;
            alrm_mask <= orc_pkg::ALRM_MASK_RESET;
            aux1_tmask <= '0;
            aux1_amask <= '0;
            aux2_mask <= '0;
            config_r <= orc_pkg::CFG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                orc_pkg::REG_TRIP_MASK: begin
                    trip_mask <= reg_wdata[orc_pkg::TRIP_W-1:0];
                end
                orc_pkg::REG_ALRM_MASK: begin
                    alrm_mask <= reg_wdata[orc_pkg::ALRM_W-1:0];
                end
                orc_pkg::REG_AUX1_TMASK: begin
                    aux1_tmask <= reg_wdata[orc_pkg::TRIP_W-1:0];
                end
                orc_pkg::REG_AUX1_AMASK: begin
                    aux1_amask <= reg_wdata[orc_pkg::ALRM_W-1:0];
                end
                orc_pkg::REG_AUX2_MASK: begin
                    aux2_mask <= reg_wdata[orc_pkg::ALRM_W-1:0];
                end
                orc_pkg::REG_CONFIG: begin
                    config_r <= reg_wdata[4:0];
                end
                default: begin
                end
            endcase
        end
    end

    // One-second enable from the clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sec_cnt <= '0;
            sec_tick <= 1'b0;
        end else if (sec_cnt == 32'(TICKS_PER_SEC - 1)) begin
            sec_cnt <= '0;
            sec_tick <= 1'b1;
        end else begin
            sec_cnt <= sec_cnt + 32'h0000_0001;
            sec_tick <= 1'b0;
        end
    end

    // Off-time credit capped at an hour
    assign off_credit = (off_seconds > 12'(orc_pkg::SEC_PER_HOUR))
        ? 12'(orc_pkg::SEC_PER_HOUR) : off_seconds;
    assign lock_load = reg_wr && (reg_addr == orc_pkg::REG_LOCKOUT);

    // Lockout countdown in seconds; only runs while powered here
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_sec <= '0;
        end else if (lock_load) begin
            lock_sec <= reg_wdata[orc_pkg::LOCK_W-1:0];
        end else if (off_valid) begin
            // Credit the time spent without control power
            lock_sec <= (lock_sec > orc_pkg::LOCK_W'(off_credit))
                ? lock_sec - orc_pkg::LOCK_W'(off_credit) : '0;
        end else if (sec_tick && power_ok && lock_active) begin
            lock_sec <= lock_sec - 1'b1;
        end
    end

    // Emergency restart strobes to thermal model and start counter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            thermal_clear <= 1'b0;
            starts_dec <= 1'b0;
        end else begin
            thermal_clear <= emg_pulse;
            starts_dec <= emg_pulse;
        end
    end

    // Interrupt events: rising activation of each output
    assign irq_evt = {trip_act, alrm_act, aux1_act, aux2_act} & ~act_prev;
    assign irq_clr = (reg_wr && reg_addr == orc_pkg::REG_IRQ_CLR)
        ? reg_wdata[orc_pkg::IRQ_W-1:0] : '0;

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            act_prev <= '0;
            irq_stat <= '0;
            irq_en <= '0;
            irq <= 1'b0;
        end else begin
            act_prev <= {trip_act, alrm_act, aux1_act, aux2_act};
            irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
            if (reg_wr && reg_addr == orc_pkg::REG_IRQ_EN) begin
                irq_en <= reg_wdata[orc_pkg::IRQ_W-1:0];
            end
            irq <= |(irq_stat & irq_en);
        end
    end

    // Read port, data one cycle after strobe, zero otherwise
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                orc_pkg::REG_TRIP_MASK: reg_rdata <= 32'(trip_mask);
                orc_pkg::REG_ALRM_MASK: reg_rdata <= 32'(alrm_mask);
                orc_pkg::REG_AUX1_TMASK: reg_rdata <= 32'(aux1_tmask);
                orc_pkg::REG_AUX1_AMASK: reg_rdata <= 32'(aux1_amask);
                orc_pkg::REG_AUX2_MASK: reg_rdata <= 32'(aux2_mask);
                orc_pkg::REG_CONFIG: reg_rdata <= 32'(config_r);
                orc_pkg::REG_LOCKOUT: reg_rdata <= 32'(lock_sec);
                orc_pkg::REG_STATUS: begin
                    reg_rdata <= 32'({lock_active, trip_act, alrm_act,
                        aux1_act, aux2_act});
                end
                orc_pkg::REG_IRQ_STAT: reg_rdata <= 32'(irq_stat);
                orc_pkg::REG_IRQ_EN: reg_rdata <= 32'(irq_en);
                default: reg_rdata <= '0; // Unmapped and write-only read 0
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule // orc_relay_ctrl
`default_nettype wire

//--- bench/orc_relay_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the relay controller
module orc_relay_ctrl_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [orc_pkg::TRIP_W-1:0] trip_cond,
    input wire logic [orc_pkg::ALRM_W-1:0] alarm_cond,
    input wire logic keypad_reset_pin,
    input wire logic ext_reset_pin,
    input wire logic emerg_restart_pin,
    input wire logic trip_coil,
    input wire logic alarm_coil,
    input wire logic aux2_coil,
    input wire logic thermal_clear,
    input wire logic starts_dec,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic pins;
    logic [3:0] quiet_cnt;
    // Any reset source or register write may move a coil
    assign pins = keypad_reset_pin | ext_reset_pin | emerg_restart_pin | reg_wr;
    // Quiet run length; six cycles drains the pin synchronisers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            quiet_cnt <= 4'h0;
        end else if (pins || alarm_cond != '0) begin
            quiet_cnt <= 4'h0;
        end else if (quiet_cnt != 4'hF) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
    end
    sequence s_trip_quiet;
        (trip_cond == '0 && !pins)[*5];
    endsequence
    property p_trip_hold;
        s_trip_quiet |=> $stable(trip_coil);
    endproperty
    property p_alarm_src;
        quiet_cnt >= 4'h6 |-> $stable(alarm_coil);
    endproperty
    property p_aux2_latch;
        $changed(aux2_coil) |-> quiet_cnt < 4'h6;
    endproperty
    property p_emerg_cause;
        $rose(thermal_clear) |-> $past(emerg_restart_pin, 2)
            || $past(emerg_restart_pin, 3) || $past(emerg_restart_pin, 4);
    endproperty
    property p_emerg_pair;
        thermal_clear == starts_dec;
    endproperty
    property p_emerg_once;
        thermal_clear |=> !thermal_clear;
    endproperty
    property p_irq_fall;
        $fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2);
    endproperty
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == '0;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip moved");
    a_alarm_src: assert property (p_alarm_src) else $error("alarm moved");
    a_aux2_latch: assert property (p_aux2_latch) else $error("aux2 moved");
    a_emerg_cause: assert property (p_emerg_cause) else $error("no cause");
    a_emerg_pair: assert property (p_emerg_pair) else $error("unpaired");
    a_emerg_once: assert property (p_emerg_once) else $error("long pulse");
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray rdata");
    c_trip: cover property ($changed(trip_coil));
    c_emerg: cover property ($rose(thermal_clear));
    c_irq: cover property ($rose(irq));
endmodule // orc_relay_ctrl_chk
bind orc_relay_ctrl orc_relay_ctrl_chk u_chk (.clk(clk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trip_cond(trip_cond), .alarm_cond(alarm_cond),
    .keypad_reset_pin(keypad_reset_pin), .ext_reset_pin(ext_reset_pin),
    .emerg_restart_pin(emerg_restart_pin), .trip_coil(trip_coil),
    .alarm_coil(alarm_coil), .aux2_coil(aux2_coil),
    .thermal_clear(thermal_clear), .starts_dec(starts_dec), .irq(irq));
`default_nettype wire

//--- bench/orc_breaker_model.sv
`timescale 1ns/1ps
`default_nettype none
// Breaker trip coil behind the trip contacts; opens after DELAY cycles
module orc_breaker_model #(
    parameter int DELAY = 2
) (
    input wire logic clk,
    input wire logic coil,
    input wire logic fail_safe,
    output logic opened
);
    logic [7:0] cnt = 8'h00;
    // Fail-safe contacts trip on drop-out, others on pick-up
    always_ff @(posedge clk) begin
        if (!(coil ^ fail_safe)) begin
            cnt <= 8'h00;
        end else if (cnt != 8'hFF) begin
            cnt <= cnt + 8'h01;
        end
    end
    assign opened = cnt >= 8'(DELAY);
endmodule // orc_breaker_model
`default_nettype wire

//--- bench/tb_orc_relay_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_orc_relay_ctrl;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [13:0] tc = 14'h0;
    logic [11:0] ac = 12'h0, off_s = 12'h0;
    logic motor_ok = 1'b1, power_ok = 1'b1, off_valid = 1'b0;
    logic kp = 1'b0, ext = 1'b0, em = 1'b0, trip_fs = 1'b1;
    logic trip_coil, alarm_coil, aux1_coil, aux2_coil, th_clr, st_dec;
    logic irq, opened;
    int bad_count = 0, checks_done = 0, em_seen = 0;
    // Rows: trip cond, alarm cond, coils on, coils held, coils after reset
    logic [37:0] rows [5] = '{{14'h0001, 12'h0, 4'h1, 4'h1, 4'h9},
        {14'h2000, 12'h0, 4'h3, 4'h1, 4'h9},
        {14'h0, 12'h001, 4'hF, 4'h9, 4'h9},
        {14'h0, 12'h800, 4'hC, 4'h8, 4'h9},
        {14'h0, 12'h020, 4'hD, 4'h9, 4'h9}};
    always #2.5 clk = ~clk;
    orc_relay_ctrl #(.TICKS_PER_SEC(10)) DUT (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trip_cond(tc),
        .alarm_cond(ac), .motor_ok(motor_ok), .power_ok(power_ok),
        .off_seconds(off_s), .off_valid(off_valid),
        .keypad_reset_pin(kp), .ext_reset_pin(ext),
        .emerg_restart_pin(em), .trip_coil(trip_coil),
        .alarm_coil(alarm_coil), .aux1_coil(aux1_coil),
        .aux2_coil(aux2_coil), .thermal_clear(th_clr),
        .starts_dec(st_dec), .irq(irq));
    // Slow breaker so a short blip of the contacts would not count
    orc_breaker_model #(.DELAY(3)) u_brk (.clk(clk), .coil(trip_coil),
        .fail_safe(trip_fs), .opened(opened));
    // Paired restart pulses
    always @(posedge clk) if (th_clr === 1'b1 && st_dec === 1'b1) em_seen++;
    task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [31:0] coils();
        return {28'h0, trip_coil, alarm_coil, aux1_coil, aux2_coil};
    endfunction
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] exp, string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(nm, exp, reg_rdata);
    endtask
    // Conditions stand two cycles, then drop
    task automatic pulse(logic [13:0] t, logic [11:0] a, logic [3:0] d,
            logic [3:0] h);
        @(posedge clk);
        tc <= t;
        ac <= a;
        repeat (2) @(posedge clk);
        #1 check("coils on", {28'h0, d}, coils());
        tc <= 14'h0;
        ac <= 12'h0;
        repeat (2) @(posedge clk);
        #1 check("coils held", {28'h0, h}, coils());
    endtask
    // Pins are held well past the two-stage synchroniser
    task automatic press(int w);
        @(posedge clk);
        if (w == 0) kp <= 1'b1; else em <= 1'b1;
        repeat (6) @(posedge clk);
        kp <= 1'b0;
        em <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100us;
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("idle", 32'h9, coils());
        rd(orc_pkg::REG_CONFIG, 32'h1, "config");
        rd(orc_pkg::REG_TRIP_MASK, 32'h3FFF, "trip mask");
        rd(8'h30, 32'h0, "unmapped");
        wr(orc_pkg::REG_AUX1_TMASK, 32'h2000);
        wr(orc_pkg::REG_AUX1_AMASK, 32'h1);
        wr(orc_pkg::REG_AUX2_MASK, 32'h800);
        foreach (rows[i]) begin
            pulse(rows[i][37:24], rows[i][23:12], rows[i][11:8],
                rows[i][7:4]);
            wr(orc_pkg::REG_COMMAND, 32'h1);
            check("reset", {28'h0, rows[i][3:0]}, coils());
        end
        // Trip plain, alarm fail-safe latched, aux1 latched
        wr(orc_pkg::REG_CONFIG, 32'h1A);
        trip_fs = 1'b0;
        check("new idle", 32'h5, coils());
        pulse(14'h0, 12'h021, 4'h3, 4'h3);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(orc_pkg::REG_IRQ_EN, 32'h8);
        pulse(14'h0001, 12'h0, 4'hB, 4'hB);
        check("breaker", 32'h1, {31'h0, opened});
        check("irq set", 32'h1, {31'h0, irq});
        // Every output has risen once by now, so all sticky bits stand
        rd(orc_pkg::REG_IRQ_STAT, 32'hF, "irq stat");
        wr(orc_pkg::REG_IRQ_CLR, 32'hF);
        check("irq clr", 32'h0, {31'h0, irq});
        motor_ok <= 1'b0;
        press(0);
        check("key refused", 32'hB, coils());
        motor_ok <= 1'b1;
        press(0);
        check("key reset", 32'h5, coils());
        check("breaker shut", 32'h0, {31'h0, opened});
        // Capped off-power credit leaves the lockout running
        pulse(14'h0002, 12'h0, 4'hD, 4'hD);
        wr(orc_pkg::REG_LOCKOUT, 32'hE74);
        off_s <= 12'hFA0;
        off_valid <= 1'b1;
        @(posedge clk);
        off_valid <= 1'b0;
        rd(orc_pkg::REG_STATUS, 32'h18, "status");
        wr(orc_pkg::REG_COMMAND, 32'h1);
        check("remote locked", 32'hD, coils());
        ext <= 1'b1;
        repeat (10) @(posedge clk);
        #1 check("ext locked", 32'hD, coils());
        ext <= 1'b0;
        // Without control power the countdown must stand still
        power_ok <= 1'b0;
        wr(orc_pkg::REG_LOCKOUT, 32'h2);
        repeat (40) @(posedge clk);
        rd(orc_pkg::REG_LOCKOUT, 32'h2, "lock held");
        power_ok <= 1'b1;
        repeat (40) @(posedge clk);
        press(1);
        check("restart", 32'h5, coils());
        check("restart pulses", 32'h1, em_seen);
        ext <= 1'b1;
        pulse(14'h0001, 12'h0, 4'hD, 4'h5);
        ext <= 1'b0;
        give_verdict();
    end
endmodule // tb_orc_relay_ctrl
`default_nettype wire
